// ---- dv/dsof_flags_tb.sv ----
/*
  Self-checking bench for the status output flags: register port
  tasks, terminal assignment and one scenario per flag except the PID alarm flag.
  Assumes the design package and a 10 MHz control clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module dsof_flags_tb;
  import dsof_pkg::*;
  logic         CLOCK_IN = 1'b0;
  logic         RST_N_IN = 1'b0;
  logic [7:0]   ADDR_IN  = 8'h00;
  logic [31:0]  WDATA_IN = 32'h0000_0000;
  logic         WR_IN    = 1'b0;
  logic         RD_IN    = 1'b0;
  dsof_status_t STATUS_IN, s;
  dsof_meas_t   MEAS_IN, m;
  logic [3:0]   TERM_OUT;
  logic [31:0]  RDATA_OUT, rv;
  logic [15:0]  hi_cyc;
  int           failures = 0, tests_run = 0, n;

  // short tick keeps the 100-tick stretch near 1000 cycles
  dsof_flags #(.TICK_CYC(10), .N_TERM(4)) u_dut (
    .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .STATUS_IN(STATUS_IN), .MEAS_IN(MEAS_IN), .TERM_OUT(TERM_OUT),
    .RDATA_OUT(RDATA_OUT));
  dsof_periph u_periph (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .TERM_IN(TERM_OUT[0]), .HIGH_CYC_OUT(hi_cyc));

  always #50 CLOCK_IN = ~CLOCK_IN;

  // ==================
  // access tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge CLOCK_IN);
    WR_IN    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    @(posedge CLOCK_IN);
    RD_IN   <= 1'b0;
    #1 d = RDATA_OUT;
  endtask
  task automatic st();
    @(posedge CLOCK_IN);
    STATUS_IN <= s;
    MEAS_IN   <= m;
  endtask
  // hysteresis flags take two cycles, so wait four before looking
  task automatic chk(input logic [3:0] e);
    repeat (4) @(posedge CLOCK_IN);
    #1 `CHK(TERM_OUT, e)
  endtask
  task automatic go(input logic [3:0] e);
    st();
    chk(e);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #5000000;
    failures++;
    print_verdict();
  end

  // ==================
  // main sequence
  initial begin
    s = '0;
    m = '0;
    m.out_current = 16'h03E8;
    STATUS_IN = s;
    MEAS_IN = m;
    repeat (20) @(posedge CLOCK_IN);
    RST_N_IN <= 1'b1;
    rd(8'h3C, rv);
    `CHK(rv, CFG_RST)
    wr(8'h04, 32'h0000_0032);
    wr(8'h05, 32'h0000_FFFF);
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h04, rv);
    `CHK(rv, 32'h0000_0032)
    rd(8'h44, rv);
    `CHK(rv, 32'h0000_0000)
    // t0 alarm, t1 light alarm, t2 forward, t3 reverse
    wr(8'h3C, 32'h3534_6263);
    s.protect_trip = 1'b1;
    s.running = 1'b1;
    s.reverse = 1'b1;
    go(4'h9);
    s = '0;
    s.light_alarm = 1'b1;
    s.running = 1'b1;
    go(4'h6);
    s.running = 1'b0;
    go(4'h2);
    s = '0;
    wr(8'h3C, 32'h0000_002B);
    s.run_cmd = 1'b1;
    go(4'h1);
    s.slow_flow_stop = 1'b1;
    go(4'h1);
    s.pid_cancel_input = 1'b1;
    go(4'h0);
    wr(8'h3C, 32'h0000_002C);
    s.pid_cancel_input = 1'b0;
    go(4'h1);
    s.slow_flow_stop = 1'b0;
    go(4'h0);
    wr(8'h3C, 32'h0000_0037);
    go(4'h0);
    s.ready = 1'b1;
    go(4'h1);
    s = '0;
    wr(8'h3C, 32'h0000_0036);
    s.remote_mode = 1'b1;
    go(4'h1);
    s.remote_mode = 1'b0;
    go(4'h0);
    wr(8'h3C, 32'h0000_0038);
    wr(8'h00, 32'h0000_2000);
    s.thermistor_hot = 1'b1;
    go(4'h1);
    wr(8'h00, 32'h0000_1000);
    chk(4'h0);
    wr(8'h3C, 32'h0000_004C);
    s.speed_dev_excess = 1'b1;
    go(4'h1);
    wr(8'h00, 32'h0001_0000);
    chk(4'h0);
    wr(8'h3C, 32'h0000_0045);
    wr(8'h00, 32'h0000_0001);
    s.pumps_all_driven = 1'b1;
    s.pump_increase_judged = 1'b1;
    go(4'h1);
    wr(8'h00, 32'h0000_0000);
    chk(4'h0);
    s = '0;
    wr(8'h3C, 32'h0000_00B4);
    wr(8'h00, 32'h0000_0034);
    s.motors_running = 3'h2;
    go(4'h1);
    s.motors_running = 3'h1;
    go(4'h0);
    wr(8'h00, 32'h0000_0036);
    s.motors_running = 3'h3;
    go(4'h1);
    s = '0;
    wr(8'h3C, 32'h0000_003B);
    m.loop_current_ua = 16'h07CF;
    go(4'h1);
    m.loop_current_ua = 16'h07D0;
    go(4'h0);
    wr(8'h3C, 32'h0000_004D);
    wr(8'h14, 32'h0000_012C);
    m.bus_volt = 16'h012B;
    go(4'h1);
    m.bus_volt = 16'h012D;
    go(4'h0);
    wr(8'h3C, 32'h0000_004F);
    wr(8'h00, 32'h0000_0200);
    wr(8'h18, 32'h0000_0190);
    m.bus_volt = 16'h018F;
    go(4'h1);
    m.bus_volt = 16'h0199;
    go(4'h1);
    m.bus_volt = 16'h019A;
    go(4'h0);
    wr(8'h00, 32'h0000_0500);
    wr(8'h1C, 32'h0000_015E);
    m.bus_volt = 16'h015D;
    go(4'h1);
    m.bus_volt = 16'h0167;
    go(4'h1);
    m.bus_volt = 16'h0168;
    go(4'h0);
    wr(8'h3C, 32'h0000_0001);
    wr(8'h20, 32'h0000_000A);
    s.run_cmd = 1'b1;
    m.ref_freq = 16'h03E8;
    m.out_freq = 16'h03ED;
    go(4'h1);
    m.out_freq = 16'h03FC;
    go(4'h0);
    wr(8'h3C, 32'h0000_0002);
    wr(8'h24, 32'h0000_01F4);
    wr(8'h28, 32'h0000_0032);
    m.out_freq = 16'h01FE;
    go(4'h1);
    m.out_freq = 16'h01D6;
    go(4'h1);
    m.out_freq = 16'h01B8;
    go(4'h0);
    wr(8'h3C, 32'h0000_0057);
    m.out_freq = 16'h01FE;
    m.ref_freq = 16'h01FE;
    go(4'h1);
    m.ref_freq = 16'h02BC;
    go(4'h0);
    wr(8'h3C, 32'h0000_0058);
    wr(8'h2C, 32'h0000_0258);
    wr(8'h30, 32'h0000_0064);
    wr(8'h00, 32'h0010_0001);
    s.pumps_all_driven = 1'b1;
    m.out_freq = 16'h0258;
    go(4'h1);
    m.out_freq = 16'h0032;
    go(4'h0);
    m.out_freq = 16'h02BC;
    go(4'h1);
    wr(8'h00, 32'h0000_0001);
    chk(4'h0);
    s = '0;
    wr(8'h3C, 32'h0000_0054);
    wr(8'h38, 32'h0000_FFFF);
    wr(8'h34, 32'h0000_0003);
    s.running = 1'b1;
    for (n = 0; n < 4; n++) begin
      s.run_time_tick = 1'b1;
      st();
      s.run_time_tick = 1'b0;
      go({3'h0, n == 3});
    end
    s = '0;
    wr(8'h3C, 32'h0000_0029);
    wr(8'h08, 32'h0000_0003);
    // two short dips under the timer must not add up
    m.out_current = 16'h0028;
    st();
    repeat (12) @(posedge CLOCK_IN);
    m.out_current = 16'h03E8;
    st();
    repeat (4) @(posedge CLOCK_IN);
    m.out_current = 16'h0028;
    st();
    repeat (12) @(posedge CLOCK_IN);
    #1 `CHK(TERM_OUT, 4'h0)
    chk(4'h0);
    repeat (60) @(posedge CLOCK_IN);
    #1 `CHK(TERM_OUT, 4'h1)
    m.out_current = 16'h03E8;
    st();
    #1 n = 0;
    while (TERM_OUT[0] === 1'b1 && n < 2000) begin
      @(posedge CLOCK_IN);
      #1 n++;
    end
    if (n >= 2000) begin
      failures++;
      print_verdict();
    end
    `CHK(n inside {[985:1015]}, 1'b1)
    @(posedge CLOCK_IN);
    #1 `CHK(hi_cyc >= 16'h03E8, 1'b1)
    wr(8'h3C, 32'h0000_002D);
    wr(8'h0C, 32'h0000_0064);
    m.torque = 16'h0032;
    go(4'h1);
    m.torque = 16'h00C8;
    go(4'h1);
    wr(8'h40, 32'h0000_0000);
    s.protect_trip = 1'b1;
    st();
    rd(8'h40, rv);
    `CHK(rv[F_ALM], 1'b1)
    print_verdict();
  end
endmodule

// ---- dv/dsof_periph.sv ----
/*
  Peripheral equipment model: reads drive output terminal 0 and
  measures how long each high pulse on it lasts, in clock cycles.
  Assumes the terminal is sampled on the drive's own clock.
*/
`timescale 1ns/1ps
module dsof_periph (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        TERM_IN,
  output logic      [15:0] HIGH_CYC_OUT
);
  // ==================
  // pulse width meter
  logic [15:0] run_q;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_q        <= 16'h0000;
      HIGH_CYC_OUT <= 16'h0000;
    end else if (TERM_IN) begin
      run_q <= run_q + 16'h0001;
    end else begin
      // latch on the falling edge only, idle time is not a pulse
      if (run_q != 16'h0000) HIGH_CYC_OUT <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

// ---- src/dsof_flags.sv ----
/*
  Drive status output flags: derives status flags from drive
  conditions and routes the assigned flag to each output terminal.
  Assumes inputs synchronous to CLOCK_IN and a single-cycle
  register strobe master.
*/
`timescale 1ns/1ps
module dsof_flags
  import dsof_pkg::*;
#(
  parameter int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS,
  parameter int N_TERM   = 4
)(
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [7:0]        ADDR_IN,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  input  wire dsof_status_t      STATUS_IN,
  input  wire dsof_meas_t        MEAS_IN,
  output logic      [N_TERM-1:0] TERM_OUT,
  output logic      [31:0]       RDATA_OUT
);

  localparam int TW = $clog2(TICK_CYC);

  // ==========================================================
  // register port
  logic [31:0] cfg_q [CFG_N];
  logic [31:0] rdata_q;
  wire  [3:0]  idx        = ADDR_IN[5:2];
  wire         cfg_hit    = (ADDR_IN[7:6] == 2'h0) &&
                            (ADDR_IN[1:0] == 2'h0);
  wire         status_hit = (ADDR_IN == REG_STATUS);
  wire [NFLAG-1:0] flags;
  wire [31:0]  rd_d = status_hit ? 32'(flags) :
                      cfg_hit    ? cfg_q[idx] : 32'h0000_0000;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg_q[i] <= CFG_RST;
      end
    end else if (WR_IN && cfg_hit) begin
      cfg_q[idx] <= WDATA_IN;
    end
  end

  // read data live for exactly the cycle after the strobe
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= RD_IN ? rd_d : 32'h0000_0000;
    end
  end
  assign RDATA_OUT = rdata_q;

  // ==========================================================
  // setting fields
  wire [7:0]  pump_mode = cfg_q[IDX_MODE][MODE_PUMP_LSB +: 8];
  wire [2:0]  pf_mode   = cfg_q[IDX_MODE][MODE_PF_LSB +: 3];
  wire [1:0]  thm_mode  = cfg_q[IDX_MODE][MODE_THM_LSB +: 2];
  wire        dev_mode  = cfg_q[IDX_MODE][MODE_DEV_BIT];
  wire [1:0]  pid_sel   = cfg_q[IDX_MODE][MODE_PID_LSB +: 2];
  wire [15:0] det_lvl   = cfg_q[IDX_DET_LVL][15:0];
  wire [15:0] det_hys   = cfg_q[IDX_DET_HYS][15:0];
  wire [15:0] aux_lvl   = cfg_q[IDX_AUX_LVL][15:0];
  wire [15:0] aux_hys   = cfg_q[IDX_AUX_HYS][15:0];
  wire [15:0] bus_lvl   = cfg_q[IDX_BUS_LVL][15:0];
  wire [15:0] freq      = MEAS_IN.out_freq;
  wire [15:0] vbus      = MEAS_IN.bus_volt;

  // ==========================================================
  // millisecond tick
  logic [TW-1:0] tick_q;
  wire           tick = (tick_q == TW'(TICK_CYC - 1));

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + TW'(1);
    end
  end

  // ==========================================================
  // timer-qualified flags with minimum on-width: 0 current, 1 torque
  wire [1:0]  tcond;
  wire [15:0] tmr [2];
  wire [1:0]  tdet;
  wire [1:0]  tflag;
  logic [15:0] tcnt_q [2];
  logic [15:0] str_q  [2];

  assign tcond[0] = MEAS_IN.out_current <= cfg_q[IDX_CUR_LVL][15:0];
  assign tcond[1] = MEAS_IN.torque < cfg_q[IDX_TRQ_LVL][15:0];
  assign tmr[0]   = cfg_q[IDX_CUR_TMR][15:0];
  assign tmr[1]   = cfg_q[IDX_TRQ_TMR][15:0];

  for (genvar c = 0; c < 2; c++) begin : g_tmr
    assign tdet[c]  = tcond[c] && (tcnt_q[c] >= tmr[c]);
    assign tflag[c] = tdet[c] || (str_q[c] != 16'h0000);  // see RL1 RL5

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        tcnt_q[c] <= 16'h0000;
        str_q[c]  <= 16'h0000;
      end else begin
        if (!tcond[c]) begin
          tcnt_q[c] <= 16'h0000;  // see RL26
        end else if (tick && tcnt_q[c] < tmr[c]) begin
          tcnt_q[c] <= tcnt_q[c] + 16'h0001;
        end
        if (tdet[c]) begin
          str_q[c] <= MIN_ON_TICKS;  // see RL25
        end else if (tick && str_q[c] != 16'h0000) begin
          str_q[c] <= str_q[c] - 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // hysteresis flags
  logic fdt_q, bus_low_q, pf_q, aux_q;
  wire  fdt_on   = freq > det_lvl;
  wire  fdt_off  = ({1'b0, freq} + {1'b0, det_hys}) < {1'b0, det_lvl};
  wire  pf_cont  = (pf_mode == PF_CONT_A) || (pf_mode == PF_CONT_B);
  wire  pf_uv    = (pf_mode == PF_UV_A) || (pf_mode == PF_UV_B);
  wire [15:0] pf_ref = pf_cont ? cfg_q[IDX_CONT_LVL][15:0]
                               : cfg_q[IDX_UV_LVL][15:0];
  wire  pf_rel   = {1'b0, vbus} >= ({1'b0, pf_ref} + PF_HYS_V);
  wire  aux_kill = (pid_sel == PID_OFF) || (pump_mode == PUMP_OFF);
  wire  aux_on   = STATUS_IN.pumps_all_driven && (freq >= aux_lvl);

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fdt_q     <= 1'b0;
      bus_low_q <= 1'b0;
      pf_q      <= 1'b0;
      aux_q     <= 1'b0;
    end else begin
      if (fdt_on) begin
        fdt_q <= 1'b1;  // see RL24
      end else if (fdt_off) begin
        fdt_q <= 1'b0;
      end
      if (vbus < bus_lvl) begin
        bus_low_q <= 1'b1;  // see RL13
      end else if (vbus > bus_lvl) begin
        bus_low_q <= 1'b0;
      end
      if (!(pf_cont || pf_uv)) begin
        pf_q <= 1'b0;
      end else if (vbus < pf_ref) begin
        pf_q <= 1'b1;  // see RL14 RL15
      end else if (pf_rel) begin
        pf_q <= 1'b0;
      end
      if (aux_kill) begin
        aux_q <= 1'b0;  // see RL19
      end else if (aux_on) begin
        aux_q <= 1'b1;  // see RL18
      end else if (freq < aux_hys) begin
        aux_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // maintenance counters, saturating
  logic [15:0] rt_q, st_q;
  logic        run_prev_q;
  wire         start_ev = STATUS_IN.running && !run_prev_q;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rt_q       <= 16'h0000;
      st_q       <= 16'h0000;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= STATUS_IN.running;
      if (STATUS_IN.run_time_tick && STATUS_IN.running &&
          rt_q != 16'hFFFF) begin
        rt_q <= rt_q + 16'h0001;
      end
      if (start_ev && st_q != 16'hFFFF) begin
        st_q <= st_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // flag vector
  wire [15:0] fdiff = (freq >= MEAS_IN.ref_freq) ?
                      freq - MEAS_IN.ref_freq : MEAS_IN.ref_freq - freq;
  wire frequency_arrival_flag = STATUS_IN.run_cmd && (MEAS_IN.ref_freq != 16'h0000) &&
             (fdiff <= cfg_q[IDX_ARR_W][15:0]);  // see RL23
  wire pid_act = !STATUS_IN.pid_cancel_input && STATUS_IN.run_cmd;
  wire mutual  = (pump_mode == PUMP_MUT_A) || (pump_mode == PUMP_MUT_B);

  assign flags[F_FAR]    = frequency_arrival_flag;
  assign flags[F_FDT]    = fdt_q;
  assign flags[F_LOWCUR] = tflag[0];  // see RL1
  assign flags[F_PIDALM] = STATUS_IN.pid_alarm;
  assign flags[F_PIDACT] = pid_act;  // see RL2 RL3
  assign flags[F_PIDSLP] = pid_act && STATUS_IN.slow_flow_stop;  // see RL4
  assign flags[F_LOWTRQ] = tflag[1];  // see RL5
  assign flags[F_FWD]    = STATUS_IN.running && !STATUS_IN.reverse;
  assign flags[F_REV]    = STATUS_IN.running && STATUS_IN.reverse;  // see RL6
  assign flags[F_RMT]    = STATUS_IN.remote_mode;  // see RL7
  assign flags[F_RUNENT] = STATUS_IN.run_cmd && STATUS_IN.ready;  // see RL8
  assign flags[F_THM]    = STATUS_IN.thermistor_hot &&
                           (thm_mode == THM_NO_ALARM);  // see RL9
  assign flags[F_BRK]    = MEAS_IN.loop_current_ua < BREAK_UA;  // see RL10
  assign flags[F_PLIM]   = (pump_mode != PUMP_OFF) &&
                           STATUS_IN.pumps_all_driven &&
                           STATUS_IN.pump_increase_judged;  // see RL11
  assign flags[F_SPDDEV] = STATUS_IN.speed_dev_excess &&
                           (dev_mode == DEV_CONTINUE);  // see RL12
  assign flags[F_BUSLOW] = bus_low_q;
  assign flags[F_PFDEC]  = pf_q;
  assign flags[F_MNT]    = (rt_q > cfg_q[IDX_MNT_TIME][15:0]) ||
                           (st_q > cfg_q[IDX_MNT_STRT][15:0]);  // see RL16
  assign flags[F_ARRDET] = frequency_arrival_flag && fdt_q;  // see RL17
  assign flags[F_AUX]    = aux_q;
  assign flags[F_LALM]   = STATUS_IN.light_alarm;  // see RL21
  assign flags[F_ALM]    = STATUS_IN.protect_trip;  // see RL20
  assign flags[F_MRUN]   = mutual &&
                           (STATUS_IN.motors_running >= MUT_MIN_RUN);  // see RL22

  // ==========================================================
  // terminal routing; unknown codes give a low terminal
  logic [N_TERM-1:0] term_q;
  wire  [N_TERM-1:0] term_d;
  wire  [NFLAG-1:0]  hit [N_TERM];

  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    for (genvar i = 0; i < NFLAG; i++) begin : g_hit
      assign hit[t][i] = cfg_q[IDX_TERM][8*t +: 8] == FLAG_CODE[i];
    end
    assign term_d[t] = |(flags & hit[t]);  // see RL25
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end
  assign TERM_OUT = term_q;

  // ==========================================================
  // checks
  wire [7:0] code0 = cfg_q[IDX_TERM][7:0];

  property p_min_on;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      $fell(tdet[0]) |-> str_q[0] == MIN_ON_TICKS && tflag[0];
  endproperty
  a_min_on: assert property (p_min_on)  // see RL1
    else $error("low current flag dropped before minimum width");

  property p_restart;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      !tcond[1] |=> tcnt_q[1] == 16'h0000;
  endproperty
  a_restart: assert property (p_restart)  // see RL26
    else $error("torque timer did not restart");

  property p_dir;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      !STATUS_IN.running |-> !flags[F_FWD] && !flags[F_REV];
  endproperty
  a_dir: assert property (p_dir)  // see RL6
    else $error("direction flag high while stopped");

  property p_sleep;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      flags[F_PIDSLP] |-> flags[F_PIDACT];
  endproperty
  a_sleep: assert property (p_sleep)  // see RL3
    else $error("sleep flag without PID active");

  property p_thm;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (code0 == FLAG_CODE[F_THM] && thm_mode != THM_NO_ALARM)
        |=> !TERM_OUT[0];
  endproperty
  a_thm: assert property (p_thm)  // see RL9
    else $error("thermistor terminal high outside mode 2");

  sequence s_fdt_rise;
    fdt_on ##1 !fdt_on && !fdt_off;
  endsequence
  property p_fdt;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      s_fdt_rise |=> fdt_q;
  endproperty
  a_fdt: assert property (p_fdt)  // see RL24
    else $error("detect flag lost inside hysteresis band");

  property p_bus;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (vbus < bus_lvl) |=> bus_low_q ##0 flags[F_BUSLOW];
  endproperty
  a_bus: assert property (p_bus)  // see RL13
    else $error("bus low flag not set");

  property p_aux;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      aux_kill |=> !aux_q;
  endproperty
  a_aux: assert property (p_aux)  // see RL19
    else $error("aux flag high with PID or pump disabled");

  property p_alm;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (code0 == FLAG_CODE[F_ALM] && STATUS_IN.protect_trip)
        |=> TERM_OUT[0];
  endproperty
  a_alm: assert property (p_alm)  // see RL20 RL25
    else $error("alarm terminal not raised");

  property p_read;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (RD_IN && status_hit) |=> RDATA_OUT == 32'($past(flags));
  endproperty
  a_read: assert property (p_read)
    else $error("status read mismatch");

endmodule

// ---- src/dsof_pkg.sv ----
/*
  Constants, register map and carrier types for the drive status
  output flag block.
  Assumes one 10 MHz control clock and a word-aligned register port.
*/
// Overview of operation
// RL1 - low current after timer, held 100 ms minimum
// RL2 - PID active: not cancelled and run command
// RL3 - PID active stays on during slow-flow stop
// RL4 - PID sleep while stopped by slow-flow stop
// RL5 - low torque after timer, 100 ms minimum pulse
// RL6 - forward/reverse flags follow direction, low stopped
// RL7 - remote flag on in remote mode
// RL8 - run entered when ready with run command
// RL9 - thermistor flag only in no-alarm mode 2
// RL10 - loop input wire break below 2 mA
// RL11 - pump limit: all driven and increase judged
// RL12 - speed deviation flag when handling continues running
// RL13 - bus low flag with level set/clear
// RL14 - modes 2/3: continue-run level, 10 V release
// RL15 - modes 4/5: undervoltage level, 10 V release
// RL16 - maintenance when run time or starts exceed preset
// RL17 - arrival-and-detect is AND of both
// RL18 - aux motor on at level, off below hysteresis
// RL19 - aux motor forced off when PID/pump off
// RL20 - general alarm on protective trip
// RL21 - light alarm flag follows light alarm
// RL22 - mutual running: mode 52/54, two motors
// RL23 - arrival while frequency error within width
// RL24 - detect above level, release below level-hysteresis
// RL25 - terminals show assigned flag, stretch by counter
// RL26 - qualifying timers restart when condition drops
package dsof_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int MIN_ON_MS      = 100;
  localparam int TICK_MS        = 1;
  localparam logic [15:0] MIN_ON_TICKS = 16'(MIN_ON_MS / TICK_MS);

  // ==========================================================
  // register map: byte offset = index * 4, status at 0x40
  localparam int CFG_N = 16;
  localparam logic [3:0] IDX_MODE     = 4'h0;
  localparam logic [3:0] IDX_CUR_LVL  = 4'h1;
  localparam logic [3:0] IDX_CUR_TMR  = 4'h2;
  localparam logic [3:0] IDX_TRQ_LVL  = 4'h3;
  localparam logic [3:0] IDX_TRQ_TMR  = 4'h4;
  localparam logic [3:0] IDX_BUS_LVL  = 4'h5;
  localparam logic [3:0] IDX_CONT_LVL = 4'h6;
  localparam logic [3:0] IDX_UV_LVL   = 4'h7;
  localparam logic [3:0] IDX_ARR_W    = 4'h8;
  localparam logic [3:0] IDX_DET_LVL  = 4'h9;
  localparam logic [3:0] IDX_DET_HYS  = 4'hA;
  localparam logic [3:0] IDX_AUX_LVL  = 4'hB;
  localparam logic [3:0] IDX_AUX_HYS  = 4'hC;
  localparam logic [3:0] IDX_MNT_TIME = 4'hD;
  localparam logic [3:0] IDX_MNT_STRT = 4'hE;
  localparam logic [3:0] IDX_TERM     = 4'hF;
  localparam logic [7:0] REG_STATUS   = 8'h40;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;

  // mode register fields
  localparam int MODE_PUMP_LSB = 0;
  localparam int MODE_PF_LSB   = 8;
  localparam int MODE_THM_LSB  = 12;
  localparam int MODE_DEV_BIT  = 16;
  localparam int MODE_PID_LSB  = 20;

  // ==========================================================
  // setting values
  localparam logic [1:0]  THM_NO_ALARM = 2'h2;
  localparam logic        DEV_CONTINUE = 1'b0;
  localparam logic [2:0]  PF_CONT_A    = 3'h2;
  localparam logic [2:0]  PF_CONT_B    = 3'h3;
  localparam logic [2:0]  PF_UV_A      = 3'h4;
  localparam logic [2:0]  PF_UV_B      = 3'h5;
  localparam logic [7:0]  PUMP_OFF     = 8'h00;
  localparam logic [7:0]  PUMP_MUT_A   = 8'h34;
  localparam logic [7:0]  PUMP_MUT_B   = 8'h36;
  localparam logic [1:0]  PID_OFF      = 2'h0;
  localparam logic [15:0] BREAK_UA     = 16'h07D0;
  localparam logic [16:0] PF_HYS_V     = 17'h0000A;
  localparam logic [2:0]  MUT_MIN_RUN  = 3'h2;

  // ==========================================================
  // flag indices and their assignment codes
  localparam int F_FAR = 0, F_FDT = 1, F_LOWCUR = 2, F_PIDALM = 3;
  localparam int F_PIDACT = 4, F_PIDSLP = 5, F_LOWTRQ = 6, F_FWD = 7;
  localparam int F_REV = 8, F_RMT = 9, F_RUNENT = 10, F_THM = 11;
  localparam int F_BRK = 12, F_PLIM = 13, F_SPDDEV = 14, F_BUSLOW = 15;
  localparam int F_PFDEC = 16, F_MNT = 17, F_ARRDET = 18, F_AUX = 19;
  localparam int F_LALM = 20, F_ALM = 21, F_MRUN = 22, NFLAG = 23;
  localparam logic [7:0] FLAG_CODE [NFLAG] = '{
    8'h01, 8'h02, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h34,
    8'h35, 8'h36, 8'h37, 8'h38, 8'h3B, 8'h45, 8'h4C, 8'h4D,
    8'h4F, 8'h54, 8'h57, 8'h58, 8'h62, 8'h63, 8'hB4};

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       run_cmd;
    logic       running;
    logic       reverse;
    logic       ready;
    logic       pid_cancel_input;
    logic       slow_flow_stop;
    logic       remote_mode;
    logic       thermistor_hot;
    logic       speed_dev_excess;
    logic       pid_alarm;
    logic       light_alarm;
    logic       protect_trip;
    logic       pumps_all_driven;
    logic       pump_increase_judged;
    logic       run_time_tick;
    logic [2:0] motors_running;
  } dsof_status_t;

  typedef struct packed {
    logic [15:0] out_current;
    logic [15:0] torque;
    logic [15:0] loop_current_ua;
    logic [15:0] bus_volt;
    logic [15:0] out_freq;
    logic [15:0] ref_freq;
  } dsof_meas_t;

endpackage
